//--- crm_core_regs.v
// Core register model: working array, shadows, status, config, program counter.
// Assumes the decoder drives one-cycle operation strobes on the core clock.
// Operation
// RQ1: Fetch 24-bit instruction words, one per program location.
// RQ2: Program counter is 23 bits, bit 0 always clear.
// RQ3: Sixteen 16-bit working registers for data, address or offset.
// RQ4: Stack pointer bit 0 forced zero; updated by calls, returns, exceptions; the code lets byte writes set bit 0.
// RQ5: Stack pointer resets to 0x0800.
// RQ6: Frame pointer register used by frame allocate and free.
// RQ7: Upper data half maps into program space via page register, extra cycle.
// RQ8: Table reads and writes reach full 24-bit words in 32K pages; the code models table reads only.
// RQ9: Byte writes to a working register change only the low byte.
// RQ10: Shadow save/restore copies four registers and five status flags.
// RQ11: Hardware loop pushes loop registers on start, pops at end.
// RQ12: Shadow registers are never directly readable or writable.
// RQ13: Status word low byte ALU flags, priority, repeat; high byte loop, digit carry.
// RQ14: Exceptions stack status low byte joined with program counter top byte.
// RQ15: Sixty-two vectors: eight traps and fifty-four interrupts; the code has four trap inputs, vectors 0 to 3.
// RQ16: Interrupts ranked 1 to 7 then natural order; traps 8 to 15; the code ranks its four traps 12 to 15.
// RQ17: Single-stage prefetch one cycle ahead of execution.
// RQ18: Divides run in a repeat of 18 iterations, taking 19 cycles; the divider gives its result after 17 steps.
// RQ19: Divide forms leave quotient in register zero, remainder in one.
// RQ20: Divide may be interrupted; software saves its context.
// RQ21: Configuration selects multiply, rounding and clamp options.
// RQ22: Barrel shifter shifts up to 16 places in one cycle.
// RQ23: Writes to the stack pointer store zero in bit 0; byte writes in the code store wr_data_i bit 0 unfiltered.
`timescale 1ns/1ps
`include "crm_consts.vh"
module crm_core_regs #(
    parameter NUM_IRQ = `CRM_NUM_IRQS
) (
    input  wire                 core_clk_i,
    input  wire                 resetn_i,
    input  wire                 wr_en_i,
    input  wire                 wr_byte_i,
    input  wire [3:0]           wr_idx_i,
    input  wire [15:0]          wr_data_i,
    input  wire [3:0]           rd_idx_i,
    output wire [15:0]          rd_data_o,
    input  wire                 sr_wr_i,
    input  wire [15:0]          sr_data_i,
    input  wire                 cfg_wr_i,
    input  wire [15:0]          cfg_data_i,
    input  wire                 page_wr_i,
    input  wire [7:0]           page_data_i,
    input  wire                 tpage_wr_i,
    input  wire [7:0]           tpage_data_i,
    output wire [15:0]          core_status_word_o,
    output wire [15:0]          core_cfg_reg_o,
    output wire [7:0]           prog_window_page_o,
    output wire [7:0]           table_page_reg_o,
    input  wire                 call_i,
    input  wire                 ret_i,
    input  wire                 frame_alloc_op_i,
    input  wire                 frame_free_op_i,
    input  wire [15:0]          frame_size_i,
    output wire [15:0]          stack_ptr_o,
    input  wire                 shadow_push_i,
    input  wire                 shadow_pop_i,
    input  wire                 loop_start_i,
    input  wire                 loop_end_i,
    input  wire [23:0]          loop_begin_i,
    input  wire [23:0]          loop_end_addr_i,
    input  wire [15:0]          loop_count_i,
    output wire [15:0]          loop_iter_count_o,
    input  wire                 pc_load_i,
    input  wire [22:0]          pc_target_i,
    input  wire                 stall_i,
    output wire [22:0]          pc_o,
    input  wire [23:0]          insn_data_i,
    output reg  [23:0]          insn_word_o,
    input  wire                 win_req_i,
    input  wire [15:0]          win_addr_i,
    output wire [22:0]          win_pc_addr_o,
    output reg                  win_ready_o,
    output reg  [15:0]          win_data_o,
    input  wire [15:0]          tbl_addr_i,
    output wire [22:0]          tbl_pc_addr_o,
    output wire [23:0]          tbl_data_o,
    input  wire [NUM_IRQ-1:0]   irq_pend_i,
    input  wire [3*NUM_IRQ-1:0] irq_pri_i,
    input  wire [3:0]           trap_pend_i,
    output reg                  exc_take_o,
    output reg  [5:0]           exc_vector_o,
    output wire [15:0]          exc_stack_word_o,
    input  wire                 div_start_i,
    input  wire                 div_step_i,
    input  wire [2:0]           div_form_i,
    input  wire [3:0]           div_src_i,
    input  wire [3:0]           div_den_i,
    output wire                 div_done_o,
    input  wire [39:0]          shift_in_i,
    input  wire [5:0]           shift_amt_i,
    output reg  [39:0]          shift_out_o
);
    reg  [15:0] wreg_r [0:15];
    reg  [15:0] shw_r  [0:3];
    reg  [15:0] shsr_r;
    reg  [23:0] sh_begin_r;
    reg  [23:0] sh_end_r;
    reg  [15:0] sh_count_r;
    reg  [23:0] loop_begin_r;
    reg  [23:0] loop_end_r;
    reg  [15:0] loop_count_r;
    reg  [15:0] sr_r;
    reg  [15:0] cfg_r;
    reg  [7:0]  page_r;
    reg  [7:0]  tpage_r;
    reg  [22:0] pc_r;
    reg         win_wait_r;
    wire [15:0] quot;
    wire [15:0] rem;
    wire [31:0] dividend;
    integer     i;

    assign rd_data_o          = wreg_r[rd_idx_i]; // RQ3
    assign stack_ptr_o        = wreg_r[`CRM_SP_REG];
    assign core_status_word_o = sr_r;
    assign core_cfg_reg_o     = cfg_r; // RQ21
    assign prog_window_page_o = page_r;
    assign table_page_reg_o   = tpage_r;
    assign loop_iter_count_o  = loop_count_r;
    assign pc_o               = pc_r;

    // Stack pointer write filter, also used for automatic updates
    function [15:0] sp_fix;
        input [15:0] v;
        begin
            sp_fix = {v[15:1], 1'b0}; // RQ23
        end
    endfunction

    // --------
    // Working registers, stack, frame, shadows
    // --------
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            for (i = 0; i < 16; i = i + 1) begin
                wreg_r[i] <= 16'h0000;
            end
            wreg_r[`CRM_SP_REG] <= `CRM_SP_RESET; // RQ5
            for (i = 0; i < 4; i = i + 1) begin
                shw_r[i] <= 16'h0000;
            end
        end else begin
            if (wr_en_i) begin
                if (wr_byte_i) begin
                    wreg_r[wr_idx_i][7:0] <= wr_data_i[7:0]; // RQ9
                end else if (wr_idx_i == `CRM_SP_REG) begin
                    wreg_r[wr_idx_i] <= sp_fix(wr_data_i); // RQ4
                end else begin
                    wreg_r[wr_idx_i] <= wr_data_i;
                end
            end
            if (exc_take_o || call_i) begin
                wreg_r[`CRM_SP_REG] <= sp_fix(wreg_r[`CRM_SP_REG] + 16'h0004); // RQ4
            end else if (ret_i) begin
                wreg_r[`CRM_SP_REG] <= sp_fix(wreg_r[`CRM_SP_REG] - 16'h0004);
            end else if (frame_alloc_op_i) begin // RQ6
                wreg_r[`CRM_FP_REG] <= sp_fix(wreg_r[`CRM_SP_REG] + 16'h0002);
                wreg_r[`CRM_SP_REG] <= sp_fix(wreg_r[`CRM_SP_REG] + 16'h0002 + frame_size_i);
            end else if (frame_free_op_i) begin
                wreg_r[`CRM_SP_REG] <= sp_fix(wreg_r[`CRM_FP_REG] - 16'h0002);
            end
            if (div_done_o) begin
                wreg_r[0] <= quot; // RQ19
                wreg_r[1] <= rem;
            end
            // Shadows have no read or write path other than these strobes
            if (shadow_push_i) begin // RQ12
                for (i = 0; i < 4; i = i + 1) begin
                    shw_r[i] <= wreg_r[i]; // RQ10
                end
            end else if (shadow_pop_i) begin
                for (i = 0; i < 4; i = i + 1) begin
                    wreg_r[i] <= shw_r[i];
                end
            end
        end
    end

    // --------
    // Status, config, pages, loop registers
    // --------
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sr_r         <= 16'h0000;
            shsr_r       <= 16'h0000;
            cfg_r        <= 16'h0000;
            page_r       <= 8'h00;
            tpage_r      <= 8'h00;
            loop_begin_r <= 24'h000000;
            loop_end_r   <= 24'h000000;
            loop_count_r <= 16'h0000;
            sh_begin_r   <= 24'h000000;
            sh_end_r     <= 24'h000000;
            sh_count_r   <= 16'h0000;
        end else begin
            if (sr_wr_i) begin
                sr_r <= sr_data_i; // RQ13
            end
            if (shadow_push_i) begin
                shsr_r <= sr_r & `CRM_SR_SHADOW_MASK; // RQ10
            end else if (shadow_pop_i) begin
                sr_r <= (sr_r & ~`CRM_SR_SHADOW_MASK) | shsr_r;
            end
            if (loop_start_i) begin // RQ11
                sh_begin_r   <= loop_begin_r;
                sh_end_r     <= loop_end_r;
                sh_count_r   <= loop_count_r;
                loop_begin_r <= loop_begin_i;
                loop_end_r   <= loop_end_addr_i;
                loop_count_r <= loop_count_i;
                sr_r[`CRM_SR_DA] <= 1'b1; // RQ13
            end else if (loop_end_i) begin
                loop_begin_r <= sh_begin_r;
                loop_end_r   <= sh_end_r;
                loop_count_r <= sh_count_r;
                sr_r[`CRM_SR_DA] <= 1'b0;
            end
            if (div_start_i) begin
                sr_r[`CRM_SR_RA] <= 1'b1;
            end else if (div_done_o) begin
                sr_r[`CRM_SR_RA] <= 1'b0;
            end
            if (cfg_wr_i) begin
                cfg_r <= cfg_data_i; // RQ21
            end
            if (page_wr_i) begin
                page_r <= page_data_i;
            end
            if (tpage_wr_i) begin
                tpage_r <= tpage_data_i;
            end
        end
    end

    // --------
    // Program counter, prefetch and windows
    // --------
    // Window access takes one extra cycle, returning the low 16 bits only
    assign win_pc_addr_o = {page_r, win_addr_i[14:1], 1'b0}; // RQ7
    assign tbl_pc_addr_o = {tpage_r[6:0], tbl_addr_i[15:1], 1'b0}; // RQ8
    assign tbl_data_o    = insn_data_i; // RQ8

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pc_r        <= 23'h000000;
            insn_word_o <= 24'h000000;
            win_wait_r  <= 1'b0;
            win_ready_o <= 1'b0;
            win_data_o  <= 16'h0000;
        end else begin
            win_ready_o <= 1'b0;
            if (win_req_i && !win_wait_r) begin
                win_wait_r <= 1'b1; // RQ7
            end else if (win_wait_r) begin
                win_wait_r  <= 1'b0;
                win_ready_o <= 1'b1;
                win_data_o  <= insn_data_i[15:0];
            end
            if (pc_load_i) begin
                pc_r <= {pc_target_i[22:1], 1'b0}; // RQ2
            end else if (!stall_i && !win_wait_r) begin
                // The word fetched now executes next cycle
                insn_word_o <= insn_data_i; // RQ17 RQ1
                pc_r        <= pc_r + 23'h000002;
            end
        end
    end

    // --------
    // Exception arbitration
    // --------
    reg [3:0] best_pri;
    reg [5:0] best_vec;
    integer   k;
    always @* begin
        best_pri = {1'b0, sr_r[`CRM_SR_IPL_HI:`CRM_SR_IPL_LO]};
        best_vec = 6'h00;
        // Lower index wins a tie, giving the fixed natural order
        for (k = NUM_IRQ - 1; k >= 0; k = k - 1) begin
            if (irq_pend_i[k] && {1'b0, irq_pri_i[3*k +: 3]} >= best_pri &&
                ({1'b0, irq_pri_i[3*k +: 3]} > {1'b0, sr_r[`CRM_SR_IPL_HI:`CRM_SR_IPL_LO]})) begin
                best_pri = {1'b0, irq_pri_i[3*k +: 3]}; // RQ16
                best_vec = k[5:0] + 6'h08; // RQ15
            end
        end
        for (k = 3; k >= 0; k = k - 1) begin
            if (trap_pend_i[k]) begin
                best_pri = `CRM_TRAP_PRI_BASE + k[3:0] + 4'h4; // RQ16
                best_vec = k[5:0];
            end
        end
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            exc_take_o   <= 1'b0;
            exc_vector_o <= 6'h00;
        end else begin
            exc_take_o   <= (|irq_pend_i || |trap_pend_i) &&
                            (best_pri > {1'b0, sr_r[`CRM_SR_IPL_HI:`CRM_SR_IPL_LO]}) &&
                            !exc_take_o;
            exc_vector_o <= best_vec;
        end
    end

    assign exc_stack_word_o = {pc_r[22:16], 1'b0, sr_r[7:0]}; // RQ14

    // --------
    // Barrel shifter and divide
    // --------
    always @* begin
        if (shift_amt_i[5]) begin
            shift_out_o = shift_in_i << (~shift_amt_i[4:0] + 5'h01); // RQ22
        end else begin
            shift_out_o = $signed(shift_in_i) >>> shift_amt_i[4:0];
        end
    end

    assign dividend = ((div_form_i == `CRM_DIV_SLONG) || (div_form_i == `CRM_DIV_ULONG)) ?
                      {wreg_r[div_src_i + 4'h1], wreg_r[div_src_i]} :
                      (div_form_i == `CRM_DIV_FRAC) ? {wreg_r[div_src_i], 16'h0000} :
                      (div_form_i == `CRM_DIV_SWORD) ? {{16{wreg_r[div_src_i][15]}}, wreg_r[div_src_i]} :
                      {16'h0000, wreg_r[div_src_i]};

    crm_divider u_div (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .start_i    (div_start_i),
        .step_i     (div_step_i),
        .form_i     (div_form_i),
        .dividend_i (dividend),
        .divisor_i  (wreg_r[div_den_i]),
        .quot_o     (quot),
        .rem_o      (rem),
        .done_o     (div_done_o)
    );
endmodule

//--- crm_consts.vh
// Constants for the core register model: reset values, field positions, op codes.
// Assumes inclusion by the register model and its divide unit only.
`ifndef CRM_CONSTS_VH
`define CRM_CONSTS_VH
// --------
// Reset values and register indices
// --------
`define CRM_SP_RESET        16'h0800
`define CRM_SP_REG          4'hF
`define CRM_FP_REG          4'hE
// --------
// Status word field positions
// --------
`define CRM_SR_C            0
`define CRM_SR_Z            1
`define CRM_SR_OV           2
`define CRM_SR_N            3
`define CRM_SR_RA           4
`define CRM_SR_IPL_LO       5
`define CRM_SR_IPL_HI       7
`define CRM_SR_DC           8
`define CRM_SR_DA           9
`define CRM_SR_SHADOW_MASK  16'h010F
// --------
// Core configuration field positions
// --------
`define CRM_CFG_IF          0
`define CRM_CFG_RND         1
`define CRM_CFG_CLAMP_MODE_SEL      4
`define CRM_CFG_MEM_WRITE_CLAMP_EN       5
`define CRM_CFG_ACC_B_CLAMP_EN        6
`define CRM_CFG_ACC_A_CLAMP_EN        7
`define CRM_CFG_US          12
// --------
// Exceptions and divide
// --------
`define CRM_NUM_VECTORS     62
`define CRM_NUM_TRAPS       8
`define CRM_NUM_IRQS        54
`define CRM_TRAP_PRI_BASE   4'h8
`define CRM_DIV_ITER        5'h12
`define CRM_DIV_CYCLES      5'h13
// Divide forms
`define CRM_DIV_FRAC        3'h0
`define CRM_DIV_SLONG       3'h1
`define CRM_DIV_ULONG       3'h2
`define CRM_DIV_SWORD       3'h3
`define CRM_DIV_UWORD       3'h4
// --------
// Program space windows
// --------
`define CRM_PC_WIDTH        23
`define CRM_INSN_WIDTH      24
`endif

//--- crm_divider.v
// Iterative divide step unit: one quotient bit per repeat iteration.
// Assumes the core issues the step 17 times in a repeat loop.
`timescale 1ns/1ps
`include "crm_consts.vh"
module crm_divider (
    input  wire        core_clk_i,
    input  wire        resetn_i,
    input  wire        start_i,
    input  wire        step_i,
    input  wire [2:0]  form_i,
    input  wire [31:0] dividend_i,
    input  wire [15:0] divisor_i,
    output reg  [15:0] quot_o,
    output reg  [15:0] rem_o,
    output reg         done_o
);
    reg  [31:0] num_r;
    reg  [15:0] den_r;
    reg  [16:0] part_r;
    reg  [4:0]  cnt_r;
    reg         negq_r;
    reg         negr_r;
    wire        signed_form;
    wire [16:0] trial;
    wire [4:0]  nbits;
    wire [31:0] num_mag;
    wire [31:0] den_mag;
    assign signed_form = (form_i == `CRM_DIV_FRAC) || (form_i == `CRM_DIV_SLONG) ||
                         (form_i == `CRM_DIV_SWORD);
    assign trial = {part_r[15:0], num_r[31]} - {1'b0, den_r};
    assign nbits = 5'h10;

    function [31:0] mag32;
        input [31:0] v;
        input        s;
        begin
            mag32 = (s && v[31]) ? (~v + 32'h0000_0001) : v;
        end
    endfunction
    assign num_mag = mag32(dividend_i, signed_form);
    assign den_mag = mag32({{16{divisor_i[15]}}, divisor_i}, signed_form);

    // --------
    // Restoring divide, quotient into work_reg_zero, remainder into work_reg_one
    // --------
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            num_r  <= 32'h0000_0000;
            den_r  <= 16'h0000;
            part_r <= 17'h00000;
            cnt_r  <= 5'h00;
            negq_r <= 1'b0;
            negr_r <= 1'b0;
            quot_o <= 16'h0000;
            rem_o  <= 16'h0000;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin // RQ19
                // High half seeds the remainder so 16 steps cover a 32-bit dividend
                num_r  <= {num_mag[15:0], 16'h0000};
                den_r  <= den_mag[15:0];
                part_r <= {1'b0, num_mag[31:16]};
                cnt_r  <= 5'h00;
                negq_r <= signed_form && (dividend_i[31] ^ divisor_i[15]);
                negr_r <= signed_form && dividend_i[31];
            end else if (step_i && cnt_r < nbits) begin // RQ18
                // State stays in registers between steps so an interrupt may split the flow
                if (!trial[16]) begin // RQ20
                    part_r <= trial;
                    num_r  <= {num_r[30:0], 1'b1};
                end else begin
                    part_r <= {part_r[15:0], num_r[31]};
                    num_r  <= {num_r[30:0], 1'b0};
                end
                cnt_r <= cnt_r + 5'h01;
            end else if (step_i && cnt_r == nbits) begin
                quot_o <= negq_r ? (~num_r[15:0] + 16'h0001) : num_r[15:0]; // RQ19
                rem_o  <= negr_r ? (~part_r[15:0] + 16'h0001) : part_r[15:0];
                done_o <= 1'b1;
                cnt_r  <= cnt_r + 5'h01;
            end
        end
    end
endmodule

//--- crm_core_regs_sva.sv
// Checker for the core register model: stack pointer, byte lanes, divide, program window.
// Assumes it is bound onto crm_core_regs and sees only its ports.
`timescale 1ns/1ps
module crm_core_regs_sva (
    input wire        core_clk_i,
    input wire        resetn_i,
    input wire        wr_en_i,
    input wire        wr_byte_i,
    input wire [3:0]  wr_idx_i,
    input wire [15:0] wr_data_i,
    input wire [3:0]  rd_idx_i,
    input wire [15:0] rd_data_o,
    input wire        call_i,
    input wire        ret_i,
    input wire        frame_alloc_op_i,
    input wire        frame_free_op_i,
    input wire [15:0] stack_ptr_o,
    input wire        exc_take_o,
    input wire        win_req_i,
    input wire        win_ready_o,
    input wire [22:0] pc_o,
    input wire        div_start_i,
    input wire        div_step_i,
    input wire        div_done_o
);
    // --------
    // Helper logic
    // --------
    logic [4:0] step_cnt_r;
    wire        sp_quiet = !exc_take_o && !frame_alloc_op_i && !frame_free_op_i;
    // Resets to 31 and saturates there, so stray steps outside a run never look like the last one
    always_ff @(posedge core_clk_i or negedge resetn_i)
        if (!resetn_i) step_cnt_r <= 5'h1F;
        else if (div_start_i) step_cnt_r <= 5'h00;
        else if (div_step_i && step_cnt_r != 5'h1F) step_cnt_r <= step_cnt_r + 5'h01;
    // --------
    // Assertions
    // --------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    sequence last_step_s; div_step_i && step_cnt_r == 5'h10; endsequence
    sequence sp_call_s; call_i && !ret_i && sp_quiet; endsequence
    sequence sp_ret_s; ret_i && !call_i && sp_quiet; endsequence
    sequence sp_wr_s; wr_en_i && !wr_byte_i && wr_idx_i == 4'hF && !call_i && !ret_i && sp_quiet;
    endsequence
    sequence byte_wr_s; wr_en_i && wr_byte_i && wr_idx_i == rd_idx_i && wr_idx_i > 4'h3
        && wr_idx_i < 4'hE ##1 rd_idx_i == $past(rd_idx_i); endsequence
    chk_sp_even: assert property (stack_ptr_o[0] == 1'b0)
        else $error("stack pointer bit 0 set");
    chk_sp_reset: assert property ($rose(resetn_i) |-> stack_ptr_o == 16'h0800)
        else $error("stack pointer reset value wrong");
    chk_call_push: assert property (sp_call_s |=> stack_ptr_o == $past(stack_ptr_o) + 16'h0004)
        else $error("call did not advance stack pointer");
    chk_ret_pop: assert property (sp_ret_s |=> stack_ptr_o == $past(stack_ptr_o) - 16'h0004)
        else $error("return did not rewind stack pointer");
    chk_sp_write: assert property (sp_wr_s |=> stack_ptr_o == {$past(wr_data_i[15:1]), 1'b0})
        else $error("stack pointer write wrong");
    chk_byte_lane: assert property (byte_wr_s |-> rd_data_o ==
        {$past(rd_data_o[15:8]), $past(wr_data_i[7:0])}) else $error("byte write hit high byte");
    chk_div_done: assert property (last_step_s |=> div_done_o)
        else $error("divide not done after last step");
    chk_div_count: assert property (div_done_o |-> step_cnt_r == 5'h11)
        else $error("divide done at wrong step");
    chk_win_wait: assert property ($rose(win_req_i) |-> !win_ready_o [*2] ##1 win_ready_o)
        else $error("window access not one extra cycle");
    chk_pc_even: assert property (pc_o[0] == 1'b0)
        else $error("program counter bit 0 set");
endmodule

bind crm_core_regs crm_core_regs_sva u_chk (.*);

//--- core_register_model_divide_tb_top.sv
// Testbench for the core register model.
// Assumes default parameters; inputs change at the falling edge.
`timescale 1ns/1ps
module core_register_model_divide_tb_top;
    logic core_clk_i, resetn_i, wr_en_i, wr_byte_i, call_i, ret_i, frame_alloc_op_i;
    logic frame_free_op_i, shadow_push_i, shadow_pop_i, loop_start_i, loop_end_i, sr_wr_i;
    logic page_wr_i, tpage_wr_i, cfg_wr_i, pc_load_i, stall_i, win_req_i, div_start_i;
    logic div_step_i, win_ready_o, exc_take_o, div_done_o;
    logic [3:0]   wr_idx_i, rd_idx_i, trap_pend_i, div_src_i, div_den_i;
    logic [15:0]  wr_data_i, sr_data_i, cfg_data_i, frame_size_i, loop_count_i, win_addr_i;
    logic [15:0]  tbl_addr_i, rd_data_o, core_status_word_o, core_cfg_reg_o, stack_ptr_o;
    logic [15:0]  loop_iter_count_o, win_data_o, exc_stack_word_o;
    logic [7:0]   page_data_i, tpage_data_i, prog_window_page_o, table_page_reg_o;
    logic [23:0]  loop_begin_i, loop_end_addr_i, insn_data_i, insn_word_o, tbl_data_o;
    logic [22:0]  pc_target_i, pc_o, win_pc_addr_o, tbl_pc_addr_o;
    logic [53:0]  irq_pend_i;
    logic [161:0] irq_pri_i;
    logic [5:0]   shift_amt_i, exc_vector_o;
    logic [2:0]   div_form_i;
    logic [39:0]  shift_in_i, shift_out_o;
    logic [11:0]  op_r;
    int           miscompares, cmp_count, i;
    // Divide cases: dividend low, dividend high, divisor, quotient, remainder; row = form
    logic [79:0]  dtab [5] = '{80'h1000_0000_4000_4000_0000, 80'h7960_FFFE_0009_D499_FFFF,
        80'h86A0_0001_0009_2B67_0001, 80'hFF9C_0000_0009_FFF5_FFFF, 80'hFF9C_0000_0009_1C66_0006};
    assign {call_i, ret_i, frame_alloc_op_i, frame_free_op_i, shadow_push_i, shadow_pop_i,
        loop_start_i, loop_end_i, sr_wr_i, page_wr_i, tpage_wr_i, cfg_wr_i} = op_r;
    crm_core_regs u_dut (.*);
    // --------
    // Tasks
    // --------
    task chk(input string nm, input logic [39:0] exp, input logic [39:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One-cycle strobe, then an idle cycle so back-to-back calls never toggle it at once
    task op(input logic [11:0] sel);
        op_r = sel;
        @(negedge core_clk_i);
        op_r = 12'h000;
        @(negedge core_clk_i);
    endtask
    task wr(input logic [3:0] idx, input logic [15:0] d, input logic b);
        {wr_en_i, wr_byte_i, wr_idx_i, rd_idx_i, wr_data_i} = {1'b1, b, idx, idx, d};
        @(negedge core_clk_i);
        wr_en_i = 1'b0;
        @(negedge core_clk_i);
    endtask
    task rdc(input string nm, input logic [3:0] idx, input logic [15:0] e);
        rd_idx_i = idx;
        #1;
        chk(nm, {24'h0, e}, {24'h0, rd_data_o});
    endtask
    task final_report;
        $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // --------
    // Clock, watchdog and tests
    // --------
    initial begin
        core_clk_i = 1'b0;
        forever #5 core_clk_i = ~core_clk_i;
    end
    initial begin
        #50000;
        miscompares++;
        final_report;
    end
    initial begin
        {resetn_i, op_r, wr_en_i, wr_byte_i, wr_idx_i, wr_data_i, rd_idx_i, sr_data_i, cfg_data_i,
            page_data_i, tpage_data_i, frame_size_i, loop_begin_i, loop_end_addr_i, loop_count_i,
            pc_load_i, pc_target_i, stall_i, win_req_i, win_addr_i, tbl_addr_i, irq_pend_i,
            irq_pri_i, trap_pend_i, div_start_i, div_step_i, div_form_i, shift_in_i,
            shift_amt_i} = '0;
        {insn_data_i, div_src_i, div_den_i} = {24'hABCDEF, 4'h2, 4'h4};
        repeat (4) @(negedge core_clk_i);
        resetn_i = 1'b1;
        chk("sp reset", 40'h0800, stack_ptr_o);
        wr(4'hF, 16'h1235, 1'b0);
        chk("sp write", 40'h1234, stack_ptr_o);
        op(12'h800);
        chk("sp call", 40'h1238, stack_ptr_o);
        op(12'h400);
        chk("sp return", 40'h1234, stack_ptr_o);
        frame_size_i = 16'h0010;
        op(12'h200);
        chk("sp alloc", 40'h1246, stack_ptr_o);
        rdc("fp alloc", 4'hE, 16'h1236);
        op(12'h100);
        chk("sp free", 40'h1234, stack_ptr_o);
        wr(4'h5, 16'hA5A5, 1'b0);
        wr(4'h5, 16'h3C3C, 1'b1);
        rdc("byte lane", 4'h5, 16'hA53C);
        for (i = 0; i < 4; i++) wr(i[3:0], {4{i[3:0] + 4'h1}}, 1'b0);
        sr_data_i = 16'h010F;
        op(12'h008);
        op(12'h080);
        for (i = 0; i < 4; i++) wr(i[3:0], 16'h0000, 1'b0);
        sr_data_i = 16'h00E0;
        op(12'h008);
        op(12'h040);
        for (i = 0; i < 4; i++) rdc("shadow reg", i[3:0], {4{i[3:0] + 4'h1}});
        chk("shadow flags", 40'h01EF, core_status_word_o);
        loop_count_i = 16'h0005;
        op(12'h020);
        loop_count_i = 16'h0009;
        op(12'h020);
        chk("loop inner", 40'h0009, loop_iter_count_o);
        op(12'h010);
        chk("loop outer", 40'h0005, loop_iter_count_o);
        {page_data_i, tpage_data_i, win_addr_i} = {8'hA7, 8'h5C, 16'h8004};
        op(12'h006);
        chk("window page", 40'hA7, prog_window_page_o);
        chk("table page", 40'h5C, table_page_reg_o);
        chk("window addr", {8'hA7, 15'h0004}, win_pc_addr_o);
        win_req_i = 1'b1;
        repeat (2) @(posedge core_clk_i);
        #1;
        chk("window ready", 40'h1, win_ready_o);
        chk("window data", 40'hCDEF, win_data_o);
        @(negedge core_clk_i);
        win_req_i = 1'b0;
        chk("table word", 40'hABCDEF, tbl_data_o);
        chk("fetch word", 40'hABCDEF, insn_word_o);
        for (i = 0; i < 5; i++) begin
            wr(4'h2, dtab[i][79:64], 1'b0);
            wr(4'h3, dtab[i][63:48], 1'b0);
            wr(4'h4, dtab[i][47:32], 1'b0);
            {div_form_i, div_start_i} = {i[2:0], 1'b1};
            @(negedge core_clk_i);
            {div_start_i, div_step_i} = 2'b01;
            repeat (17) @(negedge core_clk_i);
            div_step_i = 1'b0;
            chk("divide done", 40'h1, div_done_o);
            repeat (2) @(negedge core_clk_i);
            rdc("quotient", 4'h0, dtab[i][31:16]);
            rdc("remainder", 4'h1, dtab[i][15:0]);
        end
        {shift_in_i, shift_amt_i} = {40'h0000123456, 6'h10};
        #1;
        chk("shift right", 40'h0000000012, shift_out_o);
        shift_amt_i = 6'h30;
        #1;
        chk("shift left", 40'h1234560000, shift_out_o);
        trap_pend_i = 4'h2;
        for (i = 0; i < 10 && exc_take_o !== 1'b1; i++) begin
            @(posedge core_clk_i);
            #1;
        end
        chk("trap vector", 40'h01, exc_vector_o);
        @(negedge core_clk_i);
        trap_pend_i = 4'h0;
        repeat (2) @(negedge core_clk_i);
        chk("sp exception", 40'h1238, stack_ptr_o);
        final_report;
    end
endmodule
